// File: hw/vsg_cfg.svh
// constants for the video output, vertical scale and gate delay register stage
// Summary of operation
// RQ1: range clear: luma 16-253, chroma 2-253
// RQ2: range set: luma 0-255, black at 0
// RQ3: zero colour encodes as 128 on both
// RQ4: software keeps limited range with embedded timing
// RQ5: active coring zeroes luma below the limit
// RQ6: coring field: off, 8, 16, 32
// RQ7: software writes zero to reserved low bits
// RQ8: align and interlace bits pick scaling mode
// RQ9: comb bit averages adjacent chroma lines
// RQ10: ratio is five upper plus eight lower bits
// RQ11: software computes ratio from the scale equation
// RQ12: test control register always reads 0x01
// RQ13: software writes only 0x01 to test control
// RQ14: agc delay times the back porch gate
// RQ15: burst delay times the burst gate
// RQ16: reset loads high bytes 0x60, lows zero
// RQ17: reset loads burst delay 0x5D
// RQ18: reset loads agc delay 0x68
// RQ19: reset clears output format to zero
// RQ20: odd or even copy follows current field
// RQ21: delays count 4fsc ticks after sync reference
`ifndef VSG_CFG_SVH
`define VSG_CFG_SVH

// byte addresses of the register map
`define VSG_OFS_OUTPUT_FORMAT      8'h48
`define VSG_OFS_RATIO_HIGH_EVEN    8'h4c
`define VSG_OFS_RATIO_LOW_EVEN     8'h50
`define VSG_OFS_TEST_CTRL          8'h54
`define VSG_OFS_AGC_DELAY          8'h60
`define VSG_OFS_BURST_DELAY        8'h64
`define VSG_OFS_RATIO_HIGH_ODD     8'hcc
`define VSG_OFS_RATIO_LOW_ODD      8'hd0

// reset values
`define VSG_RST_OUTPUT_FORMAT      8'h00
`define VSG_RST_RATIO_HIGH         8'h60
`define VSG_RST_RATIO_LOW          8'h00
`define VSG_RST_AGC_DELAY          8'h68
`define VSG_RST_BURST_DELAY        8'h5d
`define VSG_TEST_READ_VALUE        8'h01
`define VSG_UNMAPPED_READ_VALUE    8'h00

// output format fields
`define VSG_FMT_RANGE_BIT          7
`define VSG_FMT_CORE_HI            6
`define VSG_FMT_CORE_LO            5

// vertical ratio upper byte fields
`define VSG_HI_FLDALIGN_BIT        7
`define VSG_HI_COMB_BIT            6
`define VSG_HI_INTERLACE_BIT       5
`define VSG_HI_RATIO_MSB           4
`define VSG_HI_RATIO_LSB           0

// coring limits
`define VSG_CORE_LIMIT_OFF         8'h00
`define VSG_CORE_LIMIT_8           8'h08
`define VSG_CORE_LIMIT_16          8'h10
`define VSG_CORE_LIMIT_32          8'h20

// output code limits
`define VSG_LUMA_BLACK_LIMITED     9'h010
`define VSG_LUMA_MAX_LIMITED       9'h0fd
`define VSG_CHROMA_MIN             8'h02
`define VSG_CHROMA_MAX             8'hfd
`define VSG_CHROMA_ZERO            8'h80

`endif

// File: hw/vsg_pkg.sv
// types shared by the register stage and its gate delay timers
package vsg_pkg;

  typedef enum logic [2:0] {
    VSG_MODE_NONINT      = 3'b001,
    VSG_MODE_INTERLACE   = 3'b010,
    VSG_MODE_FIELD_ALIGN = 3'b100
  } vsg_scale_mode_e;

  typedef enum logic [1:0] {
    VSG_GATE_IDLE  = 2'b01,
    VSG_GATE_COUNT = 2'b10
  } vsg_gate_state_e;

  typedef logic [7:0] vsg_byte_t;

endpackage : vsg_pkg

// File: hw/vsg_gate_timer.sv
// gate delay timer: counts 4fsc ticks from the sync reference
`timescale 1ns/1ps
`default_nettype none
module vsg_gate_timer
  import vsg_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             sync_ref,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] delay,
  output logic                  gate_open
);

  vsg_gate_state_e  state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cnt_inc;

  assign cnt_inc = cnt + {{(CNT_W-1){1'b0}}, 1'b1};

  // a new sync reference restarts the count, so a late gate is never left pending
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state     <= VSG_GATE_IDLE;
      cnt       <= '0;
      gate_open <= 1'b0;
    end else begin
      gate_open <= 1'b0;
      if (sync_ref) begin
        cnt <= '0;
        if (delay == '0) begin
          gate_open <= 1'b1;  // [RQ21]
          state     <= VSG_GATE_IDLE;
        end else begin
          state <= VSG_GATE_COUNT;
        end
      end else begin
        unique case (state)
          VSG_GATE_IDLE: begin
            cnt <= cnt;
          end
          VSG_GATE_COUNT: begin
            if (tick) begin
              cnt <= cnt_inc;
              if (cnt_inc == delay) begin
                gate_open <= 1'b1;  // [RQ21]
                state     <= VSG_GATE_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule : vsg_gate_timer
`default_nettype wire

// File: hw/vsg_regs.sv
// output format, vertical scale and gate delay register stage with its pixel path
`timescale 1ns/1ps
`default_nettype none
`include "vsg_cfg.svh"
module vsg_regs
  import vsg_pkg::*;
#(
  parameter int unsigned LINE_LEN = 1024
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        field_odd,
  input  wire logic        hsync_ref,
  input  wire logic        fsc4_tick,
  input  wire logic        pix_valid,
  input  wire logic        line_start,
  input  wire logic [7:0]  y_in,
  input  wire logic [7:0]  cb_in,
  input  wire logic [7:0]  cr_in,
  output logic      [7:0]  y_out,
  output logic      [7:0]  cb_out,
  output logic      [7:0]  cr_out,
  output logic             pix_out_valid,
  output logic      [12:0] vert_ratio,
  output vsg_scale_mode_e  scale_mode,
  output logic             comb_active,
  output logic             agc_gate,
  output logic             burst_gate
);

  localparam int unsigned IDX_W = $clog2(LINE_LEN);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(LINE_LEN - 1);
  localparam vsg_byte_t        FMT_RST  = `VSG_RST_OUTPUT_FORMAT;

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [2:0]      fmt_bits;
  vsg_byte_t       vert_ratio_high_even;
  vsg_byte_t       vert_ratio_low_even;
  vsg_byte_t       vert_ratio_high_odd;
  vsg_byte_t       vert_ratio_low_odd;
  vsg_byte_t       agc_gate_delay;
  vsg_byte_t       burst_gate_delay;
  vsg_byte_t       output_format;

  // reserved low bits are not stored and read back as zero
  assign output_format = {fmt_bits, {`VSG_FMT_CORE_LO{1'b0}}};  // [RQ7]

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fmt_bits <= FMT_RST[`VSG_FMT_RANGE_BIT:`VSG_FMT_CORE_LO];  // [RQ19]
    end else if (reg_wr && reg_addr == `VSG_OFS_OUTPUT_FORMAT) begin
      fmt_bits <= reg_wdata[`VSG_FMT_RANGE_BIT:`VSG_FMT_CORE_LO];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vert_ratio_high_even <= `VSG_RST_RATIO_HIGH;  // [RQ16]
      vert_ratio_low_even  <= `VSG_RST_RATIO_LOW;  // [RQ16]
    end else if (reg_wr) begin
      if (reg_addr == `VSG_OFS_RATIO_HIGH_EVEN) begin
        vert_ratio_high_even <= reg_wdata;
      end
      if (reg_addr == `VSG_OFS_RATIO_LOW_EVEN) begin
        vert_ratio_low_even <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vert_ratio_high_odd <= `VSG_RST_RATIO_HIGH;  // [RQ16]
      vert_ratio_low_odd  <= `VSG_RST_RATIO_LOW;  // [RQ16]
    end else if (reg_wr) begin
      if (reg_addr == `VSG_OFS_RATIO_HIGH_ODD) begin
        vert_ratio_high_odd <= reg_wdata;
      end
      if (reg_addr == `VSG_OFS_RATIO_LOW_ODD) begin
        vert_ratio_low_odd <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      agc_gate_delay   <= `VSG_RST_AGC_DELAY;  // [RQ18]
      burst_gate_delay <= `VSG_RST_BURST_DELAY;  // [RQ17]
    end else if (reg_wr) begin
      if (reg_addr == `VSG_OFS_AGC_DELAY) begin
        agc_gate_delay <= reg_wdata;
      end
      if (reg_addr == `VSG_OFS_BURST_DELAY) begin
        burst_gate_delay <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read port

  vsg_byte_t next_rdata;

  // test control keeps no state: any write is dropped so no test mode can be entered
  always_comb begin
    next_rdata = `VSG_UNMAPPED_READ_VALUE;
    unique case (reg_addr)
      `VSG_OFS_OUTPUT_FORMAT:   next_rdata = output_format;
      `VSG_OFS_RATIO_HIGH_EVEN: next_rdata = vert_ratio_high_even;
      `VSG_OFS_RATIO_LOW_EVEN:  next_rdata = vert_ratio_low_even;
      `VSG_OFS_TEST_CTRL:       next_rdata = `VSG_TEST_READ_VALUE;  // [RQ12] [RQ13]
      `VSG_OFS_AGC_DELAY:       next_rdata = agc_gate_delay;
      `VSG_OFS_BURST_DELAY:     next_rdata = burst_gate_delay;
      `VSG_OFS_RATIO_HIGH_ODD:  next_rdata = vert_ratio_high_odd;
      `VSG_OFS_RATIO_LOW_ODD:   next_rdata = vert_ratio_low_odd;
      default:                  next_rdata = `VSG_UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata  <= `VSG_UNMAPPED_READ_VALUE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // field dependent vertical scaling controls

  vsg_byte_t       field_high;
  vsg_byte_t       field_low;
  vsg_scale_mode_e next_scale_mode;

  // field copy switches with the field flag, one cycle ahead of the outputs
  assign field_high = field_odd ? vert_ratio_high_odd : vert_ratio_high_even;  // [RQ20]
  assign field_low  = field_odd ? vert_ratio_low_odd : vert_ratio_low_even;  // [RQ20]

  always_comb begin
    if (field_high[`VSG_HI_INTERLACE_BIT]) begin
      next_scale_mode = VSG_MODE_INTERLACE;  // [RQ8]
    end else if (field_high[`VSG_HI_FLDALIGN_BIT]) begin
      next_scale_mode = VSG_MODE_FIELD_ALIGN;  // [RQ8]
    end else begin
      next_scale_mode = VSG_MODE_NONINT;  // [RQ8]
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vert_ratio  <= 13'h0000;
      scale_mode  <= VSG_MODE_INTERLACE;
      comb_active <= 1'b1;
    end else begin
      vert_ratio  <= {field_high[`VSG_HI_RATIO_MSB:`VSG_HI_RATIO_LSB], field_low};  // [RQ10]
      scale_mode  <= next_scale_mode;
      comb_active <= field_high[`VSG_HI_COMB_BIT];  // [RQ9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // gate delay timers

  vsg_gate_timer #(
    .CNT_W (8)
  ) u_agc_timer (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .sync_ref  (hsync_ref),
    .tick      (fsc4_tick),
    .delay     (agc_gate_delay),
    .gate_open (agc_gate)
  );  // [RQ14]

  vsg_gate_timer #(
    .CNT_W (8)
  ) u_burst_timer (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .sync_ref  (hsync_ref),
    .tick      (fsc4_tick),
    .delay     (burst_gate_delay),
    .gate_open (burst_gate)
  );  // [RQ15]

  ////////////////////////////////////////////////////////////////////////////////
  // chroma line store

  logic [7:0]       cb_store [LINE_LEN];
  logic [7:0]       cr_store [LINE_LEN];
  logic [IDX_W-1:0] pix_idx;
  logic [IDX_W-1:0] cur_idx;

  assign cur_idx = line_start ? '0 : pix_idx;

  // index saturates so an overlong line reuses the last slot instead of wrapping
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pix_idx <= '0;
    end else if (pix_valid) begin
      pix_idx <= (cur_idx == IDX_LAST) ? IDX_LAST : cur_idx + {{(IDX_W-1){1'b0}}, 1'b1};
    end else if (line_start) begin
      pix_idx <= '0;
    end
  end

  // cleared on reset so the first combed line averages against zero colour
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < LINE_LEN; i++) begin
        cb_store[i] <= 8'h00;
        cr_store[i] <= 8'h00;
      end
    end else if (pix_valid) begin
      cb_store[cur_idx] <= cb_in;  // [RQ9]
      cr_store[cur_idx] <= cr_in;  // [RQ9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // chroma path

  logic [8:0] cb_sum;
  logic [8:0] cr_sum;
  logic [7:0] cb_sel;
  logic [7:0] cr_sel;
  logic [7:0] cb_ofs;
  logic [7:0] cr_ofs;
  logic [7:0] next_cb;
  logic [7:0] next_cr;

  // signed sum then arithmetic halving rounds the average down without overflow
  assign cb_sum = {cb_in[7], cb_in} + {cb_store[cur_idx][7], cb_store[cur_idx]};
  assign cr_sum = {cr_in[7], cr_in} + {cr_store[cur_idx][7], cr_store[cur_idx]};
  assign cb_sel = field_high[`VSG_HI_COMB_BIT] ? cb_sum[8:1] : cb_in;  // [RQ9]
  assign cr_sel = field_high[`VSG_HI_COMB_BIT] ? cr_sum[8:1] : cr_in;  // [RQ9]

  // adding the zero code to a two's complement value is a flip of its sign bit
  assign cb_ofs = cb_sel ^ `VSG_CHROMA_ZERO;  // [RQ3]
  assign cr_ofs = cr_sel ^ `VSG_CHROMA_ZERO;  // [RQ3]

  always_comb begin
    next_cb = cb_ofs;
    next_cr = cr_ofs;
    if (cb_ofs < `VSG_CHROMA_MIN) begin
      next_cb = `VSG_CHROMA_MIN;  // [RQ1] [RQ2]
    end else if (cb_ofs > `VSG_CHROMA_MAX) begin
      next_cb = `VSG_CHROMA_MAX;  // [RQ1] [RQ2]
    end
    if (cr_ofs < `VSG_CHROMA_MIN) begin
      next_cr = `VSG_CHROMA_MIN;  // [RQ1] [RQ2]
    end else if (cr_ofs > `VSG_CHROMA_MAX) begin
      next_cr = `VSG_CHROMA_MAX;  // [RQ1] [RQ2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // luma path

  logic [7:0] core_limit;
  logic [7:0] y_cored;
  logic [8:0] y_shift;
  logic [7:0] next_y;

  always_comb begin
    unique case (fmt_bits[`VSG_FMT_CORE_HI-`VSG_FMT_CORE_LO:0])
      2'b00: core_limit = `VSG_CORE_LIMIT_OFF;  // [RQ6]
      2'b01: core_limit = `VSG_CORE_LIMIT_8;  // [RQ6]
      2'b10: core_limit = `VSG_CORE_LIMIT_16;  // [RQ6]
      2'b11: core_limit = `VSG_CORE_LIMIT_32;  // [RQ6]
    endcase
  end

  // coring acts on the level above black, before the limited range offset
  assign y_cored = (y_in < core_limit) ? 8'h00 : y_in;  // [RQ5]
  assign y_shift = {1'b0, y_cored} + `VSG_LUMA_BLACK_LIMITED;  // [RQ1]

  // limited range is required when embedded control codes carry timing
  always_comb begin
    if (fmt_bits[`VSG_FMT_RANGE_BIT-`VSG_FMT_CORE_LO]) begin
      next_y = y_cored;  // [RQ2]
    end else if (y_shift > `VSG_LUMA_MAX_LIMITED) begin
      next_y = 8'(`VSG_LUMA_MAX_LIMITED);  // [RQ1] [RQ4]
    end else begin
      next_y = y_shift[7:0];  // [RQ1]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pixel output registers

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      y_out         <= 8'(`VSG_LUMA_BLACK_LIMITED);
      cb_out        <= `VSG_CHROMA_ZERO;
      cr_out        <= `VSG_CHROMA_ZERO;
      pix_out_valid <= 1'b0;
    end else begin
      pix_out_valid <= pix_valid;
      if (pix_valid) begin
        y_out  <= next_y;
        cb_out <= next_cb;
        cr_out <= next_cr;
      end
    end
  end

endmodule : vsg_regs
`default_nettype wire

// File: sim/vsg_regs_asserts.sv
// port checker for the register stage, bound to vsg_regs
`timescale 1ns/1ps
`default_nettype none
module vsg_regs_asserts
  import vsg_pkg::*;
#(
  parameter int unsigned LINE_LEN = 1024
) (
  input wire logic            mclk,
  input wire logic            rst_b,
  input wire logic [7:0]      reg_addr,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic            reg_rvalid,
  input wire logic            field_odd,
  input wire logic            hsync_ref,
  input wire logic            fsc4_tick,
  input wire logic            pix_valid,
  input wire logic [7:0]      cb_in,
  input wire logic [7:0]      cb_out,
  input wire logic [7:0]      cr_out,
  input wire logic            pix_out_valid,
  input wire logic [12:0]     vert_ratio,
  input wire vsg_scale_mode_e scale_mode,
  input wire logic            comb_active,
  input wire logic            agc_gate,
  input wire logic            burst_gate
);
  default clocking dclk @(posedge mclk); endclocking
  default disable iff (!rst_b);
  //////////////////////////////////////////////////////////////////////////////
  // a write to a field copy, then one quiet cycle in the same field
  sequence s_wr_hi_odd;
    reg_wr && reg_addr == 8'hcc && field_odd ##1 field_odd && !reg_wr;
  endsequence
  sequence s_wr_lo_even;
    reg_wr && reg_addr == 8'h50 && !field_odd ##1 !field_odd && !reg_wr;
  endsequence
  property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
  property p_test_read; reg_rd && reg_addr == 8'h54 |=> reg_rdata == 8'h01; endproperty
  property p_chroma_range;
    pix_out_valid |-> cb_out >= 8'h02 && cb_out <= 8'hfd && cr_out >= 8'h02 && cr_out <= 8'hfd;
  endproperty
  // only judged with the comb off and no copy change in flight
  property p_zero_chroma;
    pix_valid && !comb_active && cb_in == 8'h00 && $stable(field_odd) && !reg_wr && !$past(reg_wr)
      |=> cb_out == 8'h80;
  endproperty
  property p_odd_high;
    s_wr_hi_odd |=> vert_ratio[12:8] == $past(reg_wdata[4:0], 2) && comb_active == $past(reg_wdata[6], 2)
      && scale_mode == ($past(reg_wdata[5], 2) ? VSG_MODE_INTERLACE
                        : ($past(reg_wdata[7], 2) ? VSG_MODE_FIELD_ALIGN : VSG_MODE_NONINT));
  endproperty
  property p_even_low; s_wr_lo_even |=> vert_ratio[7:0] == $past(reg_wdata, 2); endproperty
  property p_agc_cause; agc_gate |-> $past(fsc4_tick) || $past(hsync_ref); endproperty
  property p_burst_cause; burst_gate |-> $past(fsc4_tick) || $past(hsync_ref); endproperty
  property p_pix_answer; pix_valid |=> pix_out_valid; endproperty
  property p_reset_vals;
    $rose(rst_b) |-> scale_mode == VSG_MODE_INTERLACE && comb_active && vert_ratio == 13'h0000 && !reg_rvalid;
  endproperty
  //////////////////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_test_read: assert property (p_test_read) else $error("test register read wrong");
  a_chroma_range: assert property (p_chroma_range) else $error("chroma out of range");
  a_zero_chroma: assert property (p_zero_chroma) else $error("zero colour not 128");
  a_odd_high: assert property (p_odd_high) else $error("odd high copy not applied");
  a_even_low: assert property (p_even_low) else $error("even low copy not applied");
  a_agc_cause: assert property (p_agc_cause) else $error("agc gate without tick");
  a_burst_cause: assert property (p_burst_cause) else $error("burst gate without tick");
  a_pix_answer: assert property (p_pix_answer) else $error("pixel not answered");
  a_reset_vals: assert property (p_reset_vals) else $error("reset outputs wrong");
endmodule : vsg_regs_asserts
bind vsg_regs vsg_regs_asserts #(.LINE_LEN(LINE_LEN)) u_asserts (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .field_odd(field_odd), .hsync_ref(hsync_ref), .fsc4_tick(fsc4_tick), .pix_valid(pix_valid), .cb_in(cb_in),
  .cb_out(cb_out), .cr_out(cr_out), .pix_out_valid(pix_out_valid), .vert_ratio(vert_ratio),
  .scale_mode(scale_mode), .comb_active(comb_active), .agc_gate(agc_gate), .burst_gate(burst_gate));
`default_nettype wire

// File: sim/vsg_regs_tb.sv
// self-checking bench for the register stage
`timescale 1ns/1ps
`default_nettype none
module vsg_regs_tb
  import vsg_pkg::*;
;
  logic            mclk, rst_b, reg_wr, reg_rd, field_odd, hsync_ref, fsc4_tick, pix_valid, line_start;
  logic [7:0]      reg_addr, reg_wdata, y_in, cb_in, cr_in, reg_rdata, y_out, cb_out, cr_out;
  logic            reg_rvalid, pix_out_valid, comb_active, agc_gate, burst_gate;
  logic [12:0]     vert_ratio;
  vsg_scale_mode_e scale_mode;
  int              failures, cmp_count;
  logic [7:0] addrs [9] = '{8'h48, 8'h4c, 8'h50, 8'h54, 8'h60, 8'h64, 8'hcc, 8'hd0, 8'h58};
  logic [7:0] rstv  [9] = '{8'h00, 8'h60, 8'h00, 8'h01, 8'h68, 8'h5d, 8'h60, 8'h00, 8'h00};
  logic [7:0] rbv   [9] = '{8'he0, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
  // format, luma in, chroma in, luma out, chroma out
  logic [39:0] px [10] = '{40'h00_0000_1080, 40'h00_fa7f_fdfd, 40'h80_0080_0002, 40'h80_ff00_ff80,
    40'h20_0701_1081, 40'h20_08ff_187f, 40'h40_0f00_1080, 40'h40_1000_2080, 40'he0_1f00_0080, 40'he0_2000_2080};
  vsg_regs #(.LINE_LEN(8)) u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .field_odd(field_odd),
    .hsync_ref(hsync_ref), .fsc4_tick(fsc4_tick), .pix_valid(pix_valid), .line_start(line_start), .y_in(y_in),
    .cb_in(cb_in), .cr_in(cr_in), .y_out(y_out), .cb_out(cb_out), .cr_out(cr_out), .pix_out_valid(pix_out_valid),
    .vert_ratio(vert_ratio), .scale_mode(scale_mode), .comb_active(comb_active), .agc_gate(agc_gate),
    .burst_gate(burst_gate));
  always #4 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 chk("reg_rvalid", 13'h0001, {12'h000, reg_rvalid});
    chk("reg_rdata", {5'h00, e}, {5'h00, reg_rdata});
  endtask : rd
  task automatic fld(input logic f, input logic [12:0] r, input vsg_scale_mode_e m, input logic c);
    @(posedge mclk); field_odd <= f;
    repeat (2) @(posedge mclk);
    #1 chk("vert_ratio", r, vert_ratio);
    chk("scale_mode", {10'h000, m}, {10'h000, scale_mode});
    chk("comb_active", {12'h000, c}, {12'h000, comb_active});
  endtask : fld
  task automatic pix(input logic [7:0] y, input logic [7:0] c, input logic [7:0] ey, input logic [7:0] ec);
    @(posedge mclk); pix_valid <= 1'b1; line_start <= 1'b1; y_in <= y; cb_in <= c; cr_in <= c;
    @(posedge mclk); pix_valid <= 1'b0;
    #1 chk("pix_out_valid", 13'h0001, {12'h000, pix_out_valid});
    chk("y_out", {5'h00, ey}, {5'h00, y_out});
    chk("cb_out", {5'h00, ec}, {5'h00, cb_out});
    chk("cr_out", {5'h00, ec}, {5'h00, cr_out});
  endtask : pix
  task automatic gates(input int da, input int db);
    int ca, cb;
    ca = -1;
    cb = -1;
    wr(8'h60, da[7:0]);
    wr(8'h64, db[7:0]);
    @(posedge mclk); hsync_ref <= 1'b1;
    // ticks every other cycle so a tick count and a cycle count differ
    for (int k = 1; k < 30; k++) begin
      @(posedge mclk); hsync_ref <= 1'b0; fsc4_tick <= (k % 2 == 0);
      #1 if (agc_gate === 1'b1) ca = k;
      if (burst_gate === 1'b1) cb = k;
    end
    chk("agc_gate cycle", 13'(2 * da + 1), 13'(ca));
    chk("burst_gate cycle", 13'(2 * db + 1), 13'(cb));
  endtask : gates
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    fld(1'b0, 13'h0000, VSG_MODE_INTERLACE, 1'b1);
    for (int i = 0; i < 9; i++) rd(addrs[i], rstv[i]);
    // reserved format bits and the test register only ever see permitted values
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], (addrs[i] == 8'h54) ? 8'h01 : (addrs[i] == 8'h48) ? 8'he0 : 8'hff);
    end
    for (int i = 0; i < 9; i++) rd(addrs[i], rbv[i]);
    fld(1'b0, 13'h1fff, VSG_MODE_INTERLACE, 1'b1);
    @(posedge mclk); rst_b <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 9; i++) rd(addrs[i], rstv[i]);
    $display("test regs done");
  endtask : t_regs
  task automatic t_field;
    logic [31:0] r;
    wr(8'h4c, 8'h15);
    wr(8'h50, 8'h3c);
    wr(8'hcc, 8'hc9);
    wr(8'hd0, 8'ha7);
    fld(1'b0, 13'h153c, VSG_MODE_NONINT, 1'b0);
    fld(1'b1, 13'h09a7, VSG_MODE_FIELD_ALIGN, 1'b1);
    wr(8'hcc, 8'he0);
    fld(1'b1, 13'h00a7, VSG_MODE_INTERLACE, 1'b1);
    r = (32'h0001_0000 - (2 - 1) * 512) & 32'h0000_1fff;
    wr(8'h4c, {3'b000, r[12:8]});
    wr(8'h50, r[7:0]);
    fld(1'b0, r[12:0], VSG_MODE_NONINT, 1'b0);
    $display("test field done");
  endtask : t_field
  task automatic t_pixel;
    for (int i = 0; i < 10; i++) begin
      wr(8'h48, px[i][39:32]);
      pix(px[i][31:24], px[i][23:16], px[i][15:8], px[i][7:0]);
    end
    $display("test pixel done");
  endtask : t_pixel
  task automatic t_comb;
    wr(8'h48, 8'h80);
    @(posedge mclk); field_odd <= 1'b1;
    pix(8'h40, 8'h40, 8'h40, 8'ha0);
    pix(8'h40, 8'h00, 8'h40, 8'ha0);
    pix(8'h40, 8'hff, 8'h40, 8'h7f);
    @(posedge mclk); field_odd <= 1'b0;
    pix(8'h40, 8'h40, 8'h40, 8'hc0);
    $display("test comb done");
  endtask : t_comb
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0; rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    field_odd = 1'b0; hsync_ref = 1'b0; fsc4_tick = 1'b0; pix_valid = 1'b0; line_start = 1'b0;
    y_in = 8'h00; cb_in = 8'h00; cr_in = 8'h00; failures = 0; cmp_count = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs;
    t_field;
    t_pixel;
    t_comb;
    gates(3, 0);
    gates(0, 5);
    $display("test gates done");
    test_done;
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    $display("Error watchdog expected done seen timeout");
    test_done;
  end
endmodule : vsg_regs_tb
`default_nettype wire
